//--- hdl/tbl_boot_loader.sv
// tile boot and security loader: clock multiplier config, security load, image boot
// assumes on-chip flash byte stream and otp read port on the system clock
// What this block does
// - multiplier resets to divider 1, feedback 63, input 0
// - tile clock set by feedback, input, output dividers
// - software rewrites multiplier configuration after boot
// - pull-downs enabled on all pins during reset
// - boot begins 15 us after reset release
// - security bit 5 selects otp boot
// - image is length, program words, check word
// - magic check word skips crc verification
// - length and check word least byte first
// - program stored and started at ram zero
// - crc over length and program, reflected polynomial
// - otp holds four sectors of 512 rows
// - security register loaded from otp at power-up
// - otp contents copied to ram and run in place of flash
// - otp programmed through three dedicated ports
// - bits 0 and 1 block debug and link
// - bit 7 enables otp redundant rows
// - bits 8 to 11 lock otp sectors
// - bit 12 refuses all otp programming
// - bit 13 blocks debug access to otp
// - bits 15-21 user, 22-31 user id extension
`timescale 1ns/1ps
module tbl_boot_loader
#(
    parameter int RAM_AW = 16,
    parameter int OTP_AW = 11
)
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [23:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output tbl_pkg::tbl_pll_cfg_type pll_cfg_out,
    output logic gpio_pull_down_out,
    input wire logic flash_valid_in,
    input wire logic [7:0] flash_byte_in,
    output logic flash_ready_out,
    output logic otp_rd_out,
    output logic otp_sec_sel_out,
    output logic [OTP_AW-1:0] otp_addr_out,
    input wire logic otp_rvalid_in,
    input wire logic [31:0] otp_rdata_in,
    output logic otp_prog_out,
    output logic otp_prog_sec_out,
    output logic [15:0] otp_prog_addr_out,
    output logic [31:0] otp_prog_data_out,
    output logic otp_redundant_en_out,
    input wire logic debug_otp_req_in,
    output logic debug_otp_grant_out,
    output logic debug_tile_en_out,
    output logic link_access_en_out,
    output logic [9:0] user_id_ext_out,
    output logic ram_we_out,
    output logic [RAM_AW-1:0] ram_addr_out,
    output logic [31:0] ram_wdata_out,
    output logic run_out,
    output logic [RAM_AW-1:0] run_addr_out,
    output logic boot_fail_out
);
    import tbl_pkg::*;

    if (OTP_AW < 11 || RAM_AW < 2 || RAM_AW > 30)
    begin : g_bad_width
        $error("tbl_boot_loader: address widths unsupported");
    end

    // ------------------------------------------------------------
    // crc helpers
    // ------------------------------------------------------------
    // one byte through the reflected crc
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++)
        begin
            r = r[0] ? ((r >> 1) ^ TBL_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    // a word fed as four bytes, least significant first
    function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 4; i++)
        begin
            r = crc_byte(r, w[8*i +: 8]);
        end
        return r;
    endfunction : crc_word

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tbl_state_type state_q;
    logic [11:0] delay_q;
    logic [31:0] sec_q;
    tbl_pll_cfg_type pll_q;
    logic [31:0] len_q;
    logic [31:0] remain_q;
    logic [31:0] crc_q;
    logic [RAM_AW-1:0] waddr_q;
    logic [OTP_AW-1:0] oaddr_q;
    logic otp_pend_q;
    logic [1:0] bcnt_q;
    logic [31:0] asm_q;
    logic word_v;
    logic [31:0] word_d;
    logic [15:0] prog_addr_q;
    logic [31:0] prog_data_q;
    logic prog_refused_q;
    logic crc_ok;
    logic loading;
    logic otp_src;
    logic wr_ctrl;
    logic prog_allowed;
    logic [1:0] prog_sector;

    assign loading = (state_q == TBL_LEN) || (state_q == TBL_PROG) || (state_q == TBL_CHECK);
    // boot source chosen by security bit
    assign otp_src = sec_q[TBL_SEC_OTP_BOOT];

    // ------------------------------------------------------------
    // boot sequencer
    // ------------------------------------------------------------
    // internal reset delay, security load and image parsing
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_q <= TBL_WAIT;
            delay_q <= 12'h000;
        end
        else
        begin
            unique case (state_q)
                TBL_WAIT:
                begin
                    if (delay_q == 12'(TBL_BOOT_DELAY_CYC - 1))
                        state_q <= TBL_SEC_LOAD;
                    else
                        delay_q <= delay_q + 12'h001;
                end
                TBL_SEC_LOAD:
                begin
                    if (otp_rvalid_in)
                        state_q <= TBL_LEN;
                end
                TBL_LEN:
                begin
                    if (word_v)
                        state_q <= (word_d == 32'h0000_0000) ? TBL_CHECK : TBL_PROG;
                end
                TBL_PROG:
                begin
                    if (word_v && remain_q == 32'h0000_0001)
                        state_q <= TBL_CHECK;
                end
                TBL_CHECK:
                begin
                    if (word_v)
                        state_q <= crc_ok ? TBL_RUN : TBL_FAIL;
                end
                TBL_RUN: state_q <= TBL_RUN;
                TBL_FAIL: state_q <= TBL_FAIL;
                default: state_q <= TBL_FAIL;
            endcase
        end
    end

    // crc over length and program bytes
    assign crc_ok = (word_d == TBL_SKIP_CRC) || (word_d == ~crc_q);

    // ------------------------------------------------------------
    // word sources
    // ------------------------------------------------------------
    // flash bytes assembled least significant first
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bcnt_q <= 2'h0;
            asm_q <= 32'h0000_0000;
        end
        else if (flash_valid_in && flash_ready_out)
        begin
            asm_q <= {flash_byte_in, asm_q[31:8]};
            bcnt_q <= bcnt_q + 2'h1;
        end
    end

    assign flash_ready_out = loading && !otp_src;

    // otp words read in order from address zero
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            otp_pend_q <= 1'b0;
            oaddr_q <= '0;
        end
        else if (otp_rd_out)
            otp_pend_q <= 1'b1;
        else if (otp_rvalid_in)
        begin
            otp_pend_q <= 1'b0;
            if (loading)
                oaddr_q <= oaddr_q + OTP_AW'(1);
        end
    end

    // one security read after the delay
    assign otp_rd_out = !otp_pend_q && !otp_rvalid_in
        && ((state_q == TBL_SEC_LOAD) || (loading && otp_src));
    assign otp_sec_sel_out = (state_q == TBL_SEC_LOAD);
    assign otp_addr_out = otp_sec_sel_out ? '0 : oaddr_q;

    always_comb
    begin
        if (otp_src)
        begin
            word_v = loading && otp_rvalid_in;
            word_d = otp_rdata_in;
        end
        else
        begin
            word_v = loading && flash_valid_in && bcnt_q == 2'h3;
            word_d = {flash_byte_in, asm_q[31:8]};
        end
    end

    // ------------------------------------------------------------
    // image bookkeeping and ram writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            len_q <= 32'h0000_0000;
            remain_q <= 32'h0000_0000;
            crc_q <= TBL_CRC_INIT;
        end
        else if (word_v && state_q == TBL_LEN)
        begin
            len_q <= word_d;
            remain_q <= word_d;
            crc_q <= crc_word(TBL_CRC_INIT, word_d);
        end
        else if (word_v && state_q == TBL_PROG)
        begin
            remain_q <= remain_q - 32'h0000_0001;
            crc_q <= crc_word(crc_q, word_d);
        end
    end

    // program written from lowest ram address
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            waddr_q <= '0;
            ram_we_out <= 1'b0;
            ram_addr_out <= '0;
            ram_wdata_out <= 32'h0000_0000;
        end
        else
        begin
            ram_we_out <= word_v && state_q == TBL_PROG;
            if (word_v && state_q == TBL_PROG)
            begin
                ram_addr_out <= waddr_q;
                ram_wdata_out <= word_d;
                waddr_q <= waddr_q + RAM_AW'(1);
            end
        end
    end

    // execution starts at ram address zero
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            run_out <= 1'b0;
            boot_fail_out <= 1'b0;
        end
        else
        begin
            run_out <= state_q == TBL_CHECK && word_v && crc_ok;
            boot_fail_out <= state_q == TBL_FAIL || (state_q == TBL_CHECK && word_v && !crc_ok);
        end
    end
    assign run_addr_out = '0;

    // pull-downs held until the boot starts
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            gpio_pull_down_out <= 1'b1;
        else if (state_q != TBL_WAIT)
            gpio_pull_down_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // security register
    // ------------------------------------------------------------
    // loaded once from otp, not changed by a granted security program
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            sec_q <= 32'h0000_0000;
        else if (state_q == TBL_SEC_LOAD && otp_rvalid_in)
            sec_q <= otp_rdata_in;
    end

    assign debug_tile_en_out = !sec_q[TBL_SEC_NO_DEBUG];
    assign link_access_en_out = !sec_q[TBL_SEC_NO_LINK];
    assign otp_redundant_en_out = sec_q[TBL_SEC_REDUNDANT];
    assign debug_otp_grant_out = debug_otp_req_in && !sec_q[TBL_SEC_NO_DEBUG_OTP];
    assign user_id_ext_out = sec_q[31:TBL_SEC_USERID_LSB];

    // ------------------------------------------------------------
    // clock multiplier configuration
    // ------------------------------------------------------------
    // reset ratio sixteen
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            pll_q <= '{TBL_PLL_POST_RST, TBL_PLL_F_RST, TBL_PLL_R_RST};
        else if (reg_wr_in && reg_addr_in == TBL_PLL_CFG_OFF)
        begin
            pll_q.output_divider <= reg_wdata_in[TBL_PLL_POST_LSB +: 3];
            pll_q.feedback <= reg_wdata_in[TBL_PLL_F_LSB +: 12];
            pll_q.input_divider <= reg_wdata_in[TBL_PLL_R_LSB +: 6];
        end
    end
    assign pll_cfg_out = pll_q;

    // ------------------------------------------------------------
    // otp programming ports
    // ------------------------------------------------------------
    // address and data ports
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            prog_addr_q <= 16'h0000;
            prog_data_q <= 32'h0000_0000;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == TBL_OTP_ADDR_OFF)
                prog_addr_q <= reg_wdata_in[15:0];
            if (reg_addr_in == TBL_OTP_DATA_OFF)
                prog_data_q <= reg_wdata_in;
        end
    end

    assign wr_ctrl = reg_wr_in && reg_addr_in == TBL_OTP_CTRL_OFF && reg_wdata_in[TBL_CTRL_GO];
    assign prog_sector = prog_addr_q[$clog2(TBL_OTP_ROWS) +: 2];
    assign prog_allowed = !sec_q[TBL_SEC_MASTER_LOCK] && (reg_wdata_in[TBL_CTRL_TO_SEC]
        || !sec_q[TBL_SEC_SECTOR_LOCK_LSB + 32'(prog_sector)]);

    // programming pulse or sticky refusal
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            otp_prog_out <= 1'b0;
            otp_prog_sec_out <= 1'b0;
            prog_refused_q <= 1'b0;
        end
        else
        begin
            otp_prog_out <= wr_ctrl && prog_allowed;
            otp_prog_sec_out <= wr_ctrl && prog_allowed && reg_wdata_in[TBL_CTRL_TO_SEC];
            if (wr_ctrl && !prog_allowed)
                prog_refused_q <= 1'b1;
            else if (reg_wr_in && reg_addr_in == TBL_STATUS_OFF && reg_wdata_in[0])
                prog_refused_q <= 1'b0;
        end
    end
    assign otp_prog_addr_out = prog_addr_q;
    assign otp_prog_data_out = prog_data_q;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // security bits readable by software
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            reg_rdata_out <= 32'h0000_0000;
        else if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                TBL_PLL_CFG_OFF: reg_rdata_out <= {5'h00, pll_q.output_divider, 4'h0,
                    pll_q.feedback, 2'h0, pll_q.input_divider};
                TBL_SECURITY_OFF: reg_rdata_out <= sec_q;
                TBL_STATUS_OFF: reg_rdata_out <= {25'h000_0000, state_q, run_out,
                    boot_fail_out, state_q == TBL_RUN, prog_refused_q};
                TBL_OTP_ADDR_OFF: reg_rdata_out <= {16'h0000, prog_addr_q};
                TBL_OTP_DATA_OFF: reg_rdata_out <= prog_data_q;
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata_out <= 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // reset values of the multiplier
    chk_pll_reset_ratio: assert property (@(posedge sys_clk_in)
        $rose(rst_b_in) |-> pll_cfg_out.feedback == 12'h03f
        && pll_cfg_out.output_divider == 3'h1 && pll_cfg_out.input_divider == 6'h00)
        else $error("multiplier reset ratio wrong");

    chk_pll_write_takes: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        reg_wr_in && reg_addr_in == TBL_PLL_CFG_OFF |=> pll_cfg_out.feedback
        == $past(reg_wdata_in[TBL_PLL_F_LSB +: 12]))
        else $error("multiplier write lost");

    // no boot activity before the delay ends
    chk_boot_delay: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        delay_q < 12'(TBL_BOOT_DELAY_CYC - 1) |-> !otp_rd_out && !flash_ready_out)
        else $error("boot started before reset delay");

    chk_pull_down_held: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state_q == TBL_WAIT |-> gpio_pull_down_out)
        else $error("pull-downs released early");

    chk_boot_source: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        loading && sec_q[TBL_SEC_OTP_BOOT] |-> !flash_ready_out)
        else $error("flash read while otp boot selected");

    // failing check never starts the program
    chk_no_run_on_fail: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state_q == TBL_CHECK && word_v && word_d != TBL_SKIP_CRC && word_d != ~crc_q
        |=> !run_out ##1 boot_fail_out)
        else $error("program started after crc mismatch");

    chk_master_lock: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        wr_ctrl && sec_q[TBL_SEC_MASTER_LOCK] |=> !otp_prog_out && prog_refused_q)
        else $error("programming allowed under master lock");

    chk_sector_lock: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        wr_ctrl && !reg_wdata_in[TBL_CTRL_TO_SEC]
        && sec_q[TBL_SEC_SECTOR_LOCK_LSB + 32'(prog_sector)] |=> !otp_prog_out)
        else $error("locked sector programmed");

    chk_debug_otp_block: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        sec_q[TBL_SEC_NO_DEBUG_OTP] |-> !debug_otp_grant_out)
        else $error("debug otp access granted while blocked");

    // first ram write lands at zero
    chk_ram_start_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
        state_q == TBL_PROG && word_v && remain_q == len_q |=> ram_we_out && ram_addr_out == '0)
        else $error("first program word not at address zero");
endmodule : tbl_boot_loader

//--- hdl/tbl_pkg.sv
// package for the tile boot and security loader: register map, fields, timing
// assumes a 100 MHz system clock and a 24-bit register address space
package tbl_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [23:0] TBL_PLL_CFG_OFF = 24'h00_0000;
    localparam logic [23:0] TBL_SECURITY_OFF = 24'h00_0004;
    localparam logic [23:0] TBL_STATUS_OFF = 24'h00_0008;
    localparam logic [23:0] TBL_OTP_ADDR_OFF = 24'h10_0200;
    localparam logic [23:0] TBL_OTP_DATA_OFF = 24'h20_0100;
    localparam logic [23:0] TBL_OTP_CTRL_OFF = 24'h10_0300;
    // ------------------------------------------------------------
    // clock multiplier fields and reset values
    // ------------------------------------------------------------
    localparam int TBL_PLL_R_LSB = 0;
    localparam int TBL_PLL_F_LSB = 8;
    localparam int TBL_PLL_POST_LSB = 24;
    localparam logic [2:0] TBL_PLL_POST_RST = 3'h1;
    localparam logic [11:0] TBL_PLL_F_RST = 12'h03f;
    localparam logic [5:0] TBL_PLL_R_RST = 6'h00;
    typedef struct packed {
        logic [2:0] output_divider;
        logic [11:0] feedback;
        logic [5:0] input_divider;
    } tbl_pll_cfg_type;
    // ------------------------------------------------------------
    // security register bit positions
    // ------------------------------------------------------------
    localparam int TBL_SEC_NO_DEBUG = 0;
    localparam int TBL_SEC_NO_LINK = 1;
    localparam int TBL_SEC_OTP_BOOT = 5;
    localparam int TBL_SEC_REDUNDANT = 7;
    localparam int TBL_SEC_SECTOR_LOCK_LSB = 8;
    localparam int TBL_SEC_MASTER_LOCK = 12;
    localparam int TBL_SEC_NO_DEBUG_OTP = 13;
    localparam int TBL_SEC_USER_LSB = 15;
    localparam int TBL_SEC_USERID_LSB = 22;
    // ------------------------------------------------------------
    // otp programming control bits and geometry
    // ------------------------------------------------------------
    localparam int TBL_CTRL_GO = 0;
    localparam int TBL_CTRL_TO_SEC = 1;
    localparam int TBL_OTP_SECTORS = 4;
    localparam int TBL_OTP_ROWS = 512;
    // ------------------------------------------------------------
    // boot image constants
    // ------------------------------------------------------------
    localparam logic [31:0] TBL_SKIP_CRC = 32'h0d15_ab1e;
    localparam logic [31:0] TBL_CRC_POLY = 32'hedb8_8320;
    localparam logic [31:0] TBL_CRC_INIT = 32'hffff_ffff;
    // ------------------------------------------------------------
    // timing: internal reset sequence before boot
    // ------------------------------------------------------------
    localparam int TBL_CLK_PERIOD_NS = 10;
    localparam int TBL_BOOT_DELAY_NS = 15000;
    localparam int TBL_BOOT_DELAY_CYC = (TBL_BOOT_DELAY_NS + TBL_CLK_PERIOD_NS - 1)
        / TBL_CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        TBL_WAIT = 3'h0,
        TBL_SEC_LOAD = 3'h1,
        TBL_LEN = 3'h3,
        TBL_PROG = 3'h2,
        TBL_CHECK = 3'h6,
        TBL_RUN = 3'h7,
        TBL_FAIL = 3'h5
    } tbl_state_type;
endpackage : tbl_pkg

//--- verification/tbl_boot_loader_tb.sv
// bench: three boots with flash images, register and otp lock traffic
// assumes the otp model sits on the otp read port
`timescale 1ns/1ps
module tbl_boot_loader_tb;
    import tbl_pkg::*;
    logic sys_clk_in, rst_b_in, reg_wr_in, reg_rd_in, flash_valid_in;
    logic debug_otp_req_in, gpio_pull_down_out, flash_ready_out, otp_rd_out, otp_sec_sel_out;
    logic otp_rvalid_in, otp_prog_out, ram_we_out, run_out, boot_fail_out, otp_redundant_en_out;
    logic debug_otp_grant_out, debug_tile_en_out, link_access_en_out, ok;
    logic [23:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, otp_rdata_in, ram_wdata_out, rdata, sec, r, d;
    logic [31:0] prog[$], img[$];
    logic [7:0] flash_byte_in;
    logic [10:0] otp_addr_out;
    logic [9:0] user_id_ext_out;
    logic [15:0] ram_addr_out, run_addr_out, otp_prog_addr_out;
    logic [14:0] low[3] = '{15'h0200, 15'h2083, 15'h1000};
    logic [31:0] seed = 32'd27;
    tbl_pll_cfg_type pll_cfg_out;
    int num_errors = 0, comparisons = 0, wr_idx, runs, fails, progs = 0, n, p0;
    tbl_boot_loader tbl_boot_loader_inst (.sys_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pll_cfg_out, .gpio_pull_down_out,
        .flash_valid_in, .flash_byte_in, .flash_ready_out, .otp_rd_out, .otp_sec_sel_out,
        .otp_addr_out, .otp_rvalid_in, .otp_rdata_in, .otp_prog_out, .otp_prog_sec_out(),
        .otp_prog_addr_out, .otp_prog_data_out(), .otp_redundant_en_out, .debug_otp_req_in,
        .debug_otp_grant_out, .debug_tile_en_out, .link_access_en_out, .user_id_ext_out,
        .ram_we_out, .ram_addr_out, .ram_wdata_out, .run_out, .run_addr_out, .boot_fail_out);
    tbl_otp_model tbl_otp_model_inst (.clk_in(sys_clk_in), .rst_b_in, .rd_in(otp_rd_out),
        .sec_sel_in(otp_sec_sel_out), .addr_in(otp_addr_out), .sec_word_in(sec),
        .rvalid_out(otp_rvalid_in), .rdata_out(otp_rdata_in));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // reflected crc over words sent least byte first, inverted at the end
    function automatic logic [31:0] crc_of(logic [31:0] w[$]);
        logic [31:0] c = 32'hffff_ffff;
        foreach (w[i])
            for (int b = 0; b < 32; b++)
                c = (c >> 1) ^ ((c[0] ^ w[i][b]) ? 32'hedb8_8320 : 32'h0);
        return ~c;
    endfunction : crc_of
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic reg_wr(logic [23:0] a, logic [31:0] v);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask : reg_wr
    task automatic reg_rd(logic [23:0] a);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        rdata = reg_rdata_out;
        @(posedge sys_clk_in);
    endtask : reg_rd
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // --------------------------------------------------------------
    // clock, watchdog, ram and pulse monitor
    // --------------------------------------------------------------
    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk_in);
        num_errors++;
        wrap_up();
    end
    always @(posedge sys_clk_in)
    begin
        // words land from ram zero upward
        if (ram_we_out === 1'b1)
        begin
            check("ram_addr", wr_idx, {16'h0, ram_addr_out});
            check("ram_data", prog[wr_idx], ram_wdata_out);
            wr_idx++;
        end
        runs += (run_out === 1'b1);
        fails += (boot_fail_out === 1'b1 && fails == 0);
        progs += (otp_prog_out === 1'b1);
    end
    // --------------------------------------------------------------
    // main sequence: good crc, bad crc, skip word with empty image
    // --------------------------------------------------------------
    initial
    begin
        {rst_b_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {flash_valid_in, flash_byte_in, sec} = '0;
        for (int m = 0; m < 3; m++)
        begin
            r = rnd();
            sec = {r[31:15], low[m]};
            {rst_b_in, debug_otp_req_in} <= {1'b0, r[14]};
            repeat (2) @(posedge sys_clk_in);
            // reset state of clock setup and pins
            check("pll_rst", {11'h0, 3'h1, 12'h03f, 6'h00}, {11'h0, pll_cfg_out});
            check("pull_down", 1, gpio_pull_down_out);
            rst_b_in <= 1'b1;
            n = (m == 2) ? 0 : m + 2;
            prog = {};
            repeat (n) prog.push_back(rnd());
            img = {n, prog};
            img.push_back(m == 2 ? 32'h0d15_ab1e : crc_of(img) ^ (m == 1));
            {wr_idx, runs, fails} = '0;
            foreach (img[i])
                for (int b = 0; b < 4; b++)
                begin
                    flash_valid_in <= 1'b1;
                    flash_byte_in <= img[i][8*b +: 8];
                    do @(negedge sys_clk_in); while (flash_ready_out !== 1'b1);
                    @(posedge sys_clk_in);
                end
            flash_valid_in <= 1'b0;
            repeat (3) @(posedge sys_clk_in);
            check("words", n, wr_idx);
            check("run", m != 1, runs);
            check("fail", m == 1, fails);
            check("run_addr", 0, {16'h0, run_addr_out});
            d = rnd() & 32'h07ff_ff3f;
            reg_wr(TBL_PLL_CFG_OFF, d);
            check("pll", {d[26:24], d[19:8], d[5:0]}, {11'h0, pll_cfg_out});
            reg_wr(TBL_SECURITY_OFF, ~sec);
            reg_rd(TBL_SECURITY_OFF);
            check("security", sec, rdata);
            reg_rd(24'h00_0ff0);
            check("unmapped", 0, rdata);
            check("levels", {sec[31:22], ~sec[0], ~sec[1], sec[7], ~sec[13] & r[14]},
                {user_id_ext_out, debug_tile_en_out, link_access_en_out,
                otp_redundant_en_out, debug_otp_grant_out});
            for (int s = 0; s < 2; s++)
            begin
                ok = !sec[12] && !sec[8+s];
                p0 = progs;
                reg_wr(TBL_OTP_ADDR_OFF, s << 9);
                reg_wr(TBL_OTP_DATA_OFF, rnd());
                reg_wr(TBL_OTP_CTRL_OFF, 32'h1);
                repeat (2) @(posedge sys_clk_in);
                check("prog", ok, progs - p0);
                check("prog_addr", s << 9, otp_prog_addr_out);
                reg_rd(TBL_STATUS_OFF);
                check("refused", !ok, rdata[0]);
                reg_wr(TBL_STATUS_OFF, 32'h1);
            end
        end
        wrap_up();
    end
endmodule : tbl_boot_loader_tb

//--- verification/tbl_otp_model.sv
// otp array model: answers each read with one word after a fixed delay
// assumes one read pulse per word and a security word from the bench
`timescale 1ns/1ps
module tbl_otp_model
#(
    parameter bit SLOW = 1'b1
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic rd_in,
    input wire logic sec_sel_in,
    input wire logic [10:0] addr_in,
    input wire logic [31:0] sec_word_in,
    output logic rvalid_out,
    output logic [31:0] rdata_out
);
    logic [1:0] pend_q;
    logic [31:0] w_q [2];
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pend_q <= 2'h0;
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0;
        end
        else
        begin
            pend_q <= {pend_q[0], rd_in};
            w_q[0] <= sec_sel_in ? sec_word_in : {21'h0, addr_in} ^ 32'h5a00_0000;
            w_q[1] <= w_q[0];
            rvalid_out <= pend_q[SLOW];
            // idle data toggles so stale words never look valid
            rdata_out <= pend_q[SLOW] ? w_q[SLOW] : ~rdata_out;
        end
    end
endmodule : tbl_otp_model
